// ===== udcc_control.sv
/*
  Control-input decoding and counter core for a four-decade up/down counter
  with compare register and multiplexed BCD/display port.
  Assumes three-level pins arrive as driven/level pairs from a pad sensor,
  all control pins asynchronous to core_clk, count_in already conditioned.
*/
`include "udcc_params.svh"
`timescale 1ns/100ps
`default_nettype none
module udcc_control
  import udcc_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       count_in,
  input  wire logic       store_n,
  input  wire logic       up_dn,
  input  wire logic       count_reset_n,
  input  wire udcc_pin_t  counter_load_ctl,
  input  wire udcc_pin_t  register_load_ctl,
  input  wire udcc_pin_t  display_ctl,
  input  wire logic [3:0] bcd_in,
  output logic      [3:0] bcd_out,
  output logic            bcd_oe,
  output logic      [3:0] first_digit_strobe,
  output logic      [6:0] segments,
  output logic            carry_borrow,
  output logic            equal,
  output logic            zero,
  output logic            loading
);

  function automatic udcc_tri_t tri_decode(input logic [1:0] p);
    // driven bit clear means the pin is left open
    return !p[1] ? UDCC_TRI_FLOAT : (p[0] ? UDCC_TRI_HIGH : UDCC_TRI_LOW);
  endfunction

  function automatic logic [6:0] seg_decode(input logic [3:0] d);
    case (d)
      4'h0: return 7'h3F;
      4'h1: return 7'h06;
      4'h2: return 7'h5B;
      4'h3: return 7'h4F;
      4'h4: return 7'h66;
      4'h5: return 7'h6D;
      4'h6: return 7'h7D;
      4'h7: return 7'h07;
      4'h8: return 7'h7F;
      4'h9: return 7'h6F;
      default: return 7'h00;
    endcase
  endfunction

  localparam int SCAN_W = $clog2(`UDCC_SCAN_CYCLES + 1);

  // two-stage synchronisers; stage one feeds stage two only
  logic [9:0] sync1_reg;
  logic [9:0] sync2_reg;
  logic [3:0] bcd_s1_reg;
  logic [3:0] bcd_s2_reg;
  logic       cnt_d_reg;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      // idle levels: store, up, reset high, count low, pins open; avoids a false count edge
      sync1_reg <= 10'h380;
      sync2_reg <= 10'h380;
      bcd_s1_reg <= 4'h0;
      bcd_s2_reg <= 4'h0;
    end else begin
      sync1_reg <= {store_n, up_dn, count_reset_n, count_in, 6'({counter_load_ctl, register_load_ctl, display_ctl})};
      sync2_reg <= sync1_reg;
      bcd_s1_reg <= bcd_in;
      bcd_s2_reg <= bcd_s1_reg;
    end
  end

  logic store_s;
  logic up_s;
  logic rst_s;
  logic cnt_s;
  udcc_tri_t lc_t;
  udcc_tri_t lr_t;
  udcc_tri_t dc_t;
  assign store_s = sync2_reg[9];
  assign up_s    = sync2_reg[8];
  assign rst_s   = sync2_reg[7];
  assign cnt_s   = sync2_reg[6];
  assign lc_t = tri_decode(sync2_reg[5:4]);
  assign lr_t = tri_decode(sync2_reg[3:2]);
  assign dc_t = tri_decode(sync2_reg[1:0]);

  logic cnt_edge;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cnt_d_reg <= 1'b0;
    end else begin
      cnt_d_reg <= cnt_s;
    end
  end
  assign cnt_edge = cnt_s & ~cnt_d_reg;

  logic [3:0][3:0] count_reg;
  logic [3:0][3:0] cmp_reg;
  logic [3:0][3:0] latch_reg;
  logic            carry_reg;
  udcc_state_t     state_reg;
  logic [1:0]      digit_reg;
  logic [SCAN_W-1:0] scan_reg;
  logic            scan_tick;
  logic            lc_seen_reg;
  logic            lr_seen_reg;

  logic lc_hi;
  logic lr_hi;
  logic lr_off;
  assign lc_hi  = lc_t == UDCC_TRI_HIGH;
  assign lr_hi  = lr_t == UDCC_TRI_HIGH;
  assign lr_off = lr_t == UDCC_TRI_LOW;
  assign scan_tick = scan_reg == SCAN_W'(`UDCC_SCAN_CYCLES - 1);

  // free-running internal scan clock, stopped by register-load low
  always_ff @(posedge core_clk) begin
    if (reset || lr_off || (state_reg == UDCC_ST_RUN && (lc_hi || lr_hi)) || scan_tick) begin
      scan_reg <= '0;
    end else begin
      scan_reg <= scan_reg + SCAN_W'(1);
    end
  end

  // digit counter restarts at first digit
  always_ff @(posedge core_clk) begin
    if (reset || lr_off || (state_reg == UDCC_ST_RUN && (lc_hi || lr_hi))) begin
      digit_reg <= `UDCC_DIGIT_FIRST;
    end else if (scan_tick) begin
      digit_reg <= digit_reg - 2'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_reg <= UDCC_ST_RUN;
      lc_seen_reg <= 1'b0;
      lr_seen_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        UDCC_ST_RUN: begin
          if (lc_hi || lr_hi) begin
            state_reg <= UDCC_ST_LOAD;
            lc_seen_reg <= lc_hi;
            lr_seen_reg <= lr_hi;
          end
        end
        UDCC_ST_LOAD: begin
          if (scan_tick && digit_reg == 2'h0) begin
            if (lc_hi || lr_hi) begin
              lc_seen_reg <= lc_hi;
              lr_seen_reg <= lr_hi;
            end else begin
              state_reg <= UDCC_ST_RUN;
              lc_seen_reg <= 1'b0;
              lr_seen_reg <= 1'b0;
            end
          end
        end
      endcase
    end
  end

  // counting never depends on the display state
  always_ff @(posedge core_clk) begin
    if (reset) begin
      count_reg <= '0;
      carry_reg <= 1'b0;
    end else if (!rst_s) begin
      count_reg <= '0;
      carry_reg <= 1'b0;
    end else if (state_reg == UDCC_ST_LOAD && lc_seen_reg && scan_tick) begin
      count_reg[digit_reg] <= bcd_s2_reg;
    end else if (cnt_edge) begin
      count_reg <= bcd_step(count_reg, up_s);
      // wrap out of all nines going up or all zeros going down
      carry_reg <= up_s ? (count_reg == {4{`UDCC_DIGIT_MAX}}) : (count_reg == '0);
    end
  end

  function automatic logic [15:0] bcd_step(input logic [15:0] v, input logic up);
    logic [15:0] r;
    logic        c;
    r = v;
    c = 1'b1;
    for (int i = 0; i < `UDCC_DIGITS; i++) begin
      if (c) begin
        if (up) begin
          c = r[i*4 +: 4] == `UDCC_DIGIT_MAX;
          r[i*4 +: 4] = c ? 4'h0 : r[i*4 +: 4] + 4'h1;
        end else begin
          c = r[i*4 +: 4] == 4'h0;
          r[i*4 +: 4] = c ? `UDCC_DIGIT_MAX : r[i*4 +: 4] - 4'h1;
        end
      end
    end
    return r;
  endfunction

  always_ff @(posedge core_clk) begin
    if (reset) begin
      cmp_reg <= '0;
    end else if (state_reg == UDCC_ST_LOAD && lr_seen_reg && scan_tick) begin
      cmp_reg[digit_reg] <= bcd_s2_reg;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      latch_reg <= '0;
    end else if (!store_s) begin
      latch_reg <= count_reg;
    end
  end

  // leading zero blanking: digit other than digit 0 blanked if it and all above are zero
  logic [3:0] blank_vec;
  always_comb begin
    logic lead;
    lead = 1'b1;
    for (int i = 3; i >= 0; i--) begin
      lead = lead && (latch_reg[i] == 4'h0) && (i != 0);
      blank_vec[i] = lead;
    end
  end

  udcc_disp_t disp_next;
  always_comb begin
    disp_next.bcd    = latch_reg[digit_reg];
    disp_next.blank  = blank_vec[digit_reg] && dc_t != UDCC_TRI_LOW;
    disp_next.seg_on = dc_t != UDCC_TRI_HIGH && !lr_off;
    disp_next.dig_on = !lr_off;
    disp_next.strobe = 4'h1 << digit_reg;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      bcd_out <= 4'h0;
      bcd_oe <= 1'b0;
      first_digit_strobe <= 4'h0;
      segments <= 7'h00;
      carry_borrow <= 1'b0;
      equal <= 1'b0;
      zero <= 1'b0;
    end else begin
      bcd_out <= disp_next.bcd;
      // port tri-stated when off or loading
      bcd_oe <= lc_t != UDCC_TRI_LOW && !lr_off && state_reg == UDCC_ST_RUN;
      first_digit_strobe <= disp_next.dig_on ? disp_next.strobe : 4'h0;
      // any lit digit shows segment a or b
      segments <= (disp_next.seg_on && !disp_next.blank) ? seg_decode(disp_next.bcd) : 7'h00;
      carry_borrow <= carry_reg;
      equal <= count_reg == cmp_reg;
      zero <= count_reg == '0;
    end
  end

  assign loading = state_reg == UDCC_ST_LOAD;

endmodule
`default_nettype wire

// ===== udcc_params.svh
/*
  Timing counts and field constants for the up/down counter control block.
  Assumes inclusion by the design module only.
*/
`ifndef UDCC_PARAMS_SVH
`define UDCC_PARAMS_SVH

`define UDCC_CLK_NS        8
`define UDCC_SCAN_NS       8000
`define UDCC_SCAN_CYCLES   (`UDCC_SCAN_NS / `UDCC_CLK_NS)
`define UDCC_DIGITS        4
`define UDCC_DIGIT_FIRST   2'h3
`define UDCC_DIGIT_MAX     4'h9

`endif

// ===== udcc_pkg.sv
/*
  Types shared by the up/down counter control block.
  Assumes udcc_params.svh is on the include path.
*/
package udcc_pkg;
  // decoded three-level pin
  typedef enum logic [2:0] {
    UDCC_TRI_FLOAT = 3'b001,
    UDCC_TRI_HIGH  = 3'b010,
    UDCC_TRI_LOW   = 3'b100
  } udcc_tri_t;

  // a three-level pin seen as two logic levels: driven and level
  typedef struct packed {
    logic driven;
    logic level;
  } udcc_pin_t;

  typedef enum logic [1:0] {
    UDCC_ST_RUN  = 2'b01,
    UDCC_ST_LOAD = 2'b10
  } udcc_state_t;

  typedef struct packed {
    logic        dig_on;
    logic [3:0]  strobe;
    logic        seg_on;
    logic        blank;
    logic [3:0]  bcd;
  } udcc_disp_t;
endpackage

// ===== udcc_switches.sv
/* thumbwheel switch bank; assumes one-hot digit strobes */
`timescale 1ns/100ps
`default_nettype none
module udcc_switches
  import udcc_pkg::*;
(
  input  wire logic [3:0]  first_digit_strobe,
  input  wire logic [15:0] wheel,
  output logic      [3:0]  bcd_in
);
  always_comb begin
    bcd_in = 4'h0;
    for (int d = 0; d < 4; d++)
      if (first_digit_strobe[d])
        bcd_in = wheel[d*4+:4];
  end
endmodule
`default_nettype wire

// ===== udcc_control_assertions.sv
/* port checks on udcc_control; assumes the bind below */
`timescale 1ns/100ps
`default_nettype none
module udcc_control_assertions
  import udcc_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       reset,
  input wire logic       count_reset_n,
  input wire udcc_pin_t  counter_load_ctl,
  input wire udcc_pin_t  register_load_ctl,
  input wire udcc_pin_t  display_ctl,
  input wire logic [3:0] first_digit_strobe,
  input wire logic [6:0] segments,
  input wire logic       bcd_oe,
  input wire logic       zero,
  input wire logic       loading
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // pins take a few edges through the sync stage
  wire logic rl_low = register_load_ctl == 2'b10;
  wire logic ld_hi = counter_load_ctl == 2'b11 || register_load_ctl == 2'b11;
  a_off_dark: assert property (rl_low [*6] |-> !bcd_oe && first_digit_strobe == 4'h0 && segments == 7'h00)
    else $error("display on while off");
  a_io_hiz: assert property ((counter_load_ctl == 2'b10) [*6] |-> !bcd_oe)
    else $error("port driven while off");
  a_seg_disable: assert property ((display_ctl == 2'b11) [*6] |-> segments == 7'h00)
    else $error("segments lit while disabled");
  a_top_seg_lit: assert property (segments != 7'h00 |-> segments[0] || segments[1])
    else $error("digit without a or b");
  a_load_msd: assert property ($rose(loading) |-> ##[0:2] first_digit_strobe == 4'h8)
    else $error("load not at first digit");
  a_load_lsd: assert property ($fell(loading) |-> $past(first_digit_strobe) == 4'h1 || $past(first_digit_strobe, 2) == 4'h1)
    else $error("load ended early");
  a_load_no_drive: assert property (loading && $past(loading) |-> !bcd_oe)
    else $error("port driven while loading");
  a_load_cause: assert property ($rose(loading) |-> $past(ld_hi, 2) || $past(ld_hi, 3) || $past(ld_hi, 4))
    else $error("load without a load pin");
  a_clear_zero: assert property ((!count_reset_n) [*6] |-> zero)
    else $error("counter not cleared");
  c_load: cover property ($rose(loading));
  c_off: cover property (rl_low [*6]);
  c_zeros: cover property (segments != 7'h00 && display_ctl == 2'b10);
endmodule
bind udcc_control udcc_control_assertions u_udcc_control_assertions (.core_clk, .reset, .count_reset_n,
  .counter_load_ctl, .register_load_ctl, .display_ctl, .first_digit_strobe, .segments, .bcd_oe, .zero, .loading);
`default_nettype wire

// ===== udcc_control_test.sv
/* random self-checking bench for udcc_control; assumes the 1000-cycle scan */
`timescale 1ns/100ps
`default_nettype none
module udcc_control_test
  import udcc_pkg::*;
;
  logic       core_clk, reset, count_in, store_n, up_dn, count_reset_n;
  logic       bcd_oe, carry_borrow, equal, zero, loading;
  logic [3:0] bcd_in, bcd_out, strobe;
  logic [6:0] segments;
  logic [15:0] wheel, got;
  udcc_pin_t  cl, rl, dc;
  int         failures, check_count, cnt, n, lv, m;
  logic       mod_on;
  localparam udcc_pin_t FL = 2'b00, HI = 2'b11, LO = 2'b10;

  udcc_control u_udcc_control (.core_clk, .reset, .count_in, .store_n, .up_dn, .count_reset_n,
    .counter_load_ctl(cl), .register_load_ctl(rl), .display_ctl(dc), .bcd_in, .bcd_out, .bcd_oe,
    .first_digit_strobe(strobe), .segments, .carry_borrow, .equal, .zero, .loading);
  udcc_switches u_udcc_switches (.first_digit_strobe(strobe), .wheel, .bcd_in);

  initial begin
    core_clk = 0;
    forever #4 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    if (mod_on) begin
      count_reset_n <= !equal;
    end
  end

  function automatic logic [15:0] to_bcd(int v);
    return {4'(v / 1000), 4'(v / 100 % 10), 4'(v / 10 % 10), 4'(v % 10)};
  endfunction

  task automatic tally_and_finish;
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(logic [15:0] seen, logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(int k);
    repeat (k) @(posedge core_clk);
  endtask

  // count_in high 4, low 4 cycles
  task automatic pulse(int k);
    repeat (k) begin
      cyc(1);
      count_in <= 1;
      cyc(4);
      count_in <= 0;
      cyc(3);
    end
    cyc(6);
  endtask

  task automatic wait_dig(int d);
    cnt = 0;
    // leave a digit already on, so its last cycles are never read
    while (strobe === 4'(1 << d) && cnt < 5000) begin
      cyc(1);
      cnt++;
    end
    while (strobe !== 4'(1 << d) && cnt < 5000) begin
      cyc(1);
      cnt++;
    end
    check(cnt < 5000, 1'b1);
    cyc(3);
  endtask

  task automatic read_count(logic st, output logic [15:0] v);
    store_n <= !st;
    cyc(6);
    store_n <= 1;
    for (int d = 3; d >= 0; d--) begin
      wait_dig(d);
      v[d*4+:4] = bcd_out;
    end
  endtask

  task automatic load(logic sel, logic [15:0] w);
    wheel <= w;
    if (sel)
      rl <= HI;
    else
      cl <= HI;
    cyc(10);
    check(loading, 1'b1);
    rl <= FL;
    cl <= FL;
    cnt = 0;
    while (loading === 1'b1 && cnt < 9000) begin
      cyc(1);
      cnt++;
    end
    check(loading, 1'b0);
    cyc(4);
  endtask

  initial begin
    #(8 * 95000);
    failures++;
    tally_and_finish();
  end

  initial begin
    failures = 0;
    check_count = 0;
    reset = 1;
    count_in = 0;
    store_n = 1;
    up_dn = 1;
    count_reset_n = 1;
    cl = FL;
    rl = FL;
    dc = FL;
    wheel = 16'h0000;
    mod_on = 1'b0;
    void'($urandom(32'hC165));
    cyc(2);
    reset <= 0;
    cyc(4);
    n = $urandom_range(5, 30);
    pulse(n);
    read_count(1, got);
    check(got, to_bcd(n));
    pulse(3);
    read_count(0, got);
    check(got, to_bcd(n));
    read_count(1, got);
    check(got, to_bcd(n + 3));
    up_dn <= 0;
    pulse(n + 4);
    check(carry_borrow, 1'b1);
    read_count(1, got);
    check(got, 16'h9999);
    up_dn <= 1;
    count_reset_n <= 0;
    cyc(8);
    check(zero, 1'b1);
    count_reset_n <= 1;
    lv = $urandom_range(0, 9990);
    load(0, to_bcd(lv));
    read_count(1, got);
    check(got, to_bcd(lv));
    load(1, to_bcd(lv));
    check(equal, 1'b1);
    pulse(1);
    check(equal, 1'b0);
    check(bcd_oe, 1'b1);
    rl <= LO;
    cyc(10);
    check({bcd_oe, strobe, segments}, 16'h0000);
    pulse(2);
    rl <= FL;
    cl <= LO;
    cyc(10);
    check(bcd_oe, 1'b0);
    cl <= FL;
    read_count(1, got);
    check(got, to_bcd(lv + 3));
    count_reset_n <= 0;
    cyc(8);
    count_reset_n <= 1;
    pulse(5);
    read_count(1, got);
    check(got, 16'h0005);
    dc <= HI;
    cyc(10);
    check(segments, 16'h0000);
    dc <= FL;
    wait_dig(3);
    check(segments, 16'h0000);
    dc <= LO;
    cyc(10);
    wait_dig(3);
    check(segments != 7'h00, 1'b1);
    // counter holds 0005 here; compare preset above it, equal wired back to reset
    m = $urandom_range(7, 9);
    load(1, to_bcd(m));
    mod_on <= 1'b1;
    pulse(m - 5);
    check(zero, 1'b1);
    pulse(2);
    mod_on <= 1'b0;
    read_count(1, got);
    check(got, 16'h0002);
    tally_and_finish();
  end
endmodule
`default_nettype wire
